// ===== rtl/apm_map.vh
// constants for the audio pin function mux
`ifndef APM_MAP_VH
`define APM_MAP_VH
// pin mode select codes for the shared memory pins
`define APM_MODE_GPIO 2'h0
`define APM_MODE_CFGMEM 2'h1
`define APM_MODE_LEGACY 2'h2
// link frame geometry: 256 bit clocks, slot 0 is 16 bits
`define APM_FRAME_BITS 9'h100
`define APM_FRAME_LAST 9'h0FF
`define APM_SLOT0_LAST 9'h00F
// warm reset sync pulse length in system clocks (1 us at 100 MHz)
`define APM_WARM_NS 1000
`define APM_CLK_NS 10
`define APM_WARM_CYC 8'h64
// reset values
`define APM_RST_ZERO 1'h0
`define APM_RST_ONE 1'h1
`endif

// ===== rtl/apm_sync2.v
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module apm_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // asynchronous pin levels in, synchronised out
  input wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;
  // first stage is read only by the second stage
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end
  assign q_out = sync_r;
endmodule // apm_sync2

// ===== rtl/apm_pin_mux.v
// pin function mux and power-up pin states of the audio controller
`timescale 1ns/1ns
`include "apm_map.vh"
module apm_pin_mux #(
  parameter WARM_NS = `APM_WARM_NS
) (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // pci side reset, active low, asynchronous pin
  input wire pci_reset_n_in,
  // control bits
  input wire [1:0] mem_pin_mode_in,
  input wire gp_output_in,
  input wire gp_io_two_out_in,
  input wire gp_io_three_oe_in,
  input wire gp_io_three_out_in,
  input wire sw_link_reset_bit_in,
  input wire secondary_codec_sel_in,
  input wire gp_io_one_oe_in,
  input wire gp_io_one_out_in,
  input wire link_power_down_in,
  input wire warm_reset_req_in,
  input wire legacy_irq_mode_in,
  input wire isa_irq_enable_in,
  input wire [2:0] isa_irq_req_in,
  input wire pci_irq_req_in,
  input wire clkrun_req_in,
  // configuration memory engine side
  input wire cfg_mem_clock_in,
  input wire cfg_mem_data_drive_low_in,
  output wire cfg_mem_data_rd_out,
  // legacy dma side
  input wire legacy_dma_request_n_in,
  output wire legacy_dma_grant_n_out,
  // serial link engine side
  input wire link_serial_data_in,
  output wire primary_data_out,
  output wire secondary_data_out,
  output wire [8:0] link_bit_count_out,
  // status reads
  output wire gp_io_two_rd_out,
  output wire gp_io_three_rd_out,
  output wire gp_io_one_rd_out,
  output wire volume_up_button_rd_out,
  output wire volume_down_button_rd_out,
  output wire clkrun_rd_out,
  // memory data pin, open drain
  input wire cfg_mem_data_pin_in,
  output wire cfg_mem_data_pin_out,
  output wire cfg_mem_data_pin_oe_n_out,
  // memory clock pin
  output wire cfg_mem_clock_pin_out,
  // third gpio pin
  input wire gp_io_three_pin_in,
  output wire gp_io_three_pin_out,
  output wire gp_io_three_pin_oe_n_out,
  // volume buttons
  input wire volume_up_button_n_in,
  input wire volume_down_button_n_in,
  // isa interrupt pins and pci interrupt
  output wire [2:0] isa_irq_pin_out,
  output wire [2:0] isa_irq_pin_oe_n_out,
  output wire pci_irq_n_out,
  output wire pci_irq_oe_n_out,
  // codec link pins
  input wire link_bit_clock_in,
  output wire link_frame_sync_out,
  output wire link_serial_out,
  output wire link_reset_n_out,
  input wire primary_codec_serial_in,
  input wire secondary_codec_serial_in,
  output wire secondary_pin_out,
  output wire secondary_pin_oe_n_out,
  // clock-run pin, open drain
  input wire clkrun_pin_n_in,
  output wire clkrun_pin_out,
  output wire clkrun_pin_oe_n_out
);

  ////////////////////////////////////////////////////////////////////////
  // warm reset pulse length, rounded up to whole cycles
  localparam integer WARM_CYC_I =
    (WARM_NS + `APM_CLK_NS - 1) / `APM_CLK_NS;
  localparam [7:0] WARM_CYC = WARM_CYC_I[7:0];

  // synchronised pins; buttons reset to inactive high
  wire [7:0] pins_raw;
  wire [7:0] pins_s;
  wire pci_rst_n_s;
  wire mem_data_s;
  wire gp3_s;
  wire volume_up_button_n_s;
  wire volume_down_button_n_s;
  wire bclk_s;
  wire prim_s;
  wire sec_s;
  wire clkrun_n_s;
  assign pins_raw = {cfg_mem_data_pin_in, gp_io_three_pin_in,
    volume_up_button_n_in, volume_down_button_n_in, link_bit_clock_in,
    primary_codec_serial_in, secondary_codec_serial_in, clkrun_pin_n_in};
  apm_sync2 #(.WIDTH(8), .INIT(8'hF0)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .d_in(pins_raw),
    .q_out(pins_s)
  );
  assign {mem_data_s, gp3_s, volume_up_button_n_s, volume_down_button_n_s, bclk_s, prim_s, sec_s,
    clkrun_n_s} = pins_s;
  apm_sync2 #(.WIDTH(1), .INIT(1'b0)) u_sync_rst (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .d_in(pci_reset_n_in),
    .q_out(pci_rst_n_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  reg mem_data_oe_n_r;
  reg mem_clk_r;
  reg gp3_out_r;
  reg gp3_oe_n_r;
  reg [2:0] isa_out_r;
  reg [2:0] isa_oe_n_r;
  reg pci_irq_oe_n_r;
  reg sync_r;
  reg sdo_r;
  reg link_rst_n_r;
  reg sec_out_r;
  reg sec_oe_n_r;
  reg clkrun_oe_n_r;
  reg mem_rd_r;
  reg grant_r;
  reg prim_data_r;
  reg sec_data_r;
  reg gp2_rd_r;
  reg gp3_rd_r;
  reg gp1_rd_r;
  reg volume_up_button_rd_r;
  reg volume_down_button_rd_r;
  reg clkrun_rd_r;
  reg [8:0] bit_cnt_r;
  reg [8:0] bit_cnt_nxt;
  reg bclk_d_r;
  reg [7:0] warm_cnt_r;
  wire bclk_rise;
  wire bclk_fall;
  wire link_up;

  ////////////////////////////////////////////////////////////////////////
  // bit clock edges found in the system domain from the codec clock
  assign bclk_rise = bclk_s & ~bclk_d_r;
  assign bclk_fall = ~bclk_s & bclk_d_r;
  assign link_up = link_rst_n_r & ~link_power_down_in;

  // frame bit counter; stalls while the codec clock stops
  always @* begin
    bit_cnt_nxt = bit_cnt_r;
    if (!link_up) begin
      bit_cnt_nxt = 9'h000;
    end else if (bclk_rise) begin
      if (bit_cnt_r == `APM_FRAME_LAST) begin
        bit_cnt_nxt = 9'h000;
      end else begin
        bit_cnt_nxt = bit_cnt_r + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // codec link: sync, reset, data in and out
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      bclk_d_r <= `APM_RST_ZERO;
      bit_cnt_r <= 9'h000;
      sync_r <= `APM_RST_ZERO;
      sdo_r <= `APM_RST_ZERO;
      link_rst_n_r <= `APM_RST_ZERO;
      warm_cnt_r <= 8'h00;
      prim_data_r <= `APM_RST_ZERO;
      sec_data_r <= `APM_RST_ZERO;
    end else begin
      bclk_d_r <= bclk_s;
      bit_cnt_r <= bit_cnt_nxt;
      // either reset source holds the codecs in cold reset
      link_rst_n_r <= pci_rst_n_s & ~sw_link_reset_bit_in;
      if (link_power_down_in) begin
        // warm reset pulse on sync while link is down
        if (warm_cnt_r != 8'h00) begin
          warm_cnt_r <= warm_cnt_r - 8'h01;
        end else if (warm_reset_req_in && link_rst_n_r) begin
          warm_cnt_r <= WARM_CYC;
        end
        sync_r <= (warm_cnt_r != 8'h00);
        sdo_r <= `APM_RST_ZERO;
      end else begin
        warm_cnt_r <= 8'h00;
        // high through slot 0, low through slots 1 to 12
        sync_r <= link_up && (bit_cnt_nxt <= `APM_SLOT0_LAST);
        // data launched on rising edge, shared by both codecs
        if (!link_up) begin
          sdo_r <= `APM_RST_ZERO;
        end else if (bclk_rise) begin
          sdo_r <= link_serial_data_in;
        end
      end
      // inputs sampled on falling bit clock edge
      if (bclk_fall) begin
        prim_data_r <= prim_s;
        sec_data_r <= secondary_codec_sel_in & sec_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shared pins, interrupts, gpio; all float from reset except the memory clock pin, driven high
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mem_data_oe_n_r <= `APM_RST_ONE;
      mem_clk_r <= `APM_RST_ONE;
      gp3_out_r <= `APM_RST_ZERO;
      gp3_oe_n_r <= `APM_RST_ONE;
      isa_out_r <= 3'h0;
      isa_oe_n_r <= 3'h7;
      pci_irq_oe_n_r <= `APM_RST_ONE;
      sec_out_r <= `APM_RST_ZERO;
      sec_oe_n_r <= `APM_RST_ONE;
      clkrun_oe_n_r <= `APM_RST_ONE;
      mem_rd_r <= `APM_RST_ONE;
      grant_r <= `APM_RST_ONE;
      gp2_rd_r <= `APM_RST_ONE;
      gp3_rd_r <= `APM_RST_ONE;
      gp1_rd_r <= `APM_RST_ZERO;
      volume_up_button_rd_r <= `APM_RST_ZERO;
      volume_down_button_rd_r <= `APM_RST_ZERO;
      clkrun_rd_r <= `APM_RST_ZERO;
    end else begin
      // memory pins by board mode
      case (mem_pin_mode_in)
        `APM_MODE_CFGMEM: begin
          mem_data_oe_n_r <= ~cfg_mem_data_drive_low_in;
          mem_clk_r <= cfg_mem_clock_in;
        end
        `APM_MODE_LEGACY: begin
          mem_data_oe_n_r <= `APM_RST_ONE;
          mem_clk_r <= legacy_dma_request_n_in;
        end
        default: begin
          mem_data_oe_n_r <= gp_io_two_out_in;
          mem_clk_r <= gp_output_in;
        end
      endcase
      // config and legacy reads see the pin only in their own mode, else idle high; gpio two always sees it
      mem_rd_r <= (mem_pin_mode_in == `APM_MODE_CFGMEM) ? mem_data_s : 1'b1;
      grant_r <= (mem_pin_mode_in == `APM_MODE_LEGACY) ? mem_data_s : 1'b1;
      gp2_rd_r <= mem_data_s;
      // main-powered gpio: no wake from the link when supply drops
      gp3_oe_n_r <= ~gp_io_three_oe_in;
      gp3_out_r <= gp_io_three_out_in;
      gp3_rd_r <= gp3_s;
      // buttons pressed low; unconnected pin pulled inactive high
      volume_up_button_rd_r <= ~volume_up_button_n_s;
      volume_down_button_rd_r <= ~volume_down_button_n_s;
      // legacy mode steers interrupt off the pci line
      if (legacy_irq_mode_in && isa_irq_enable_in) begin
        isa_oe_n_r <= 3'h0;
        isa_out_r <= isa_irq_req_in;
        pci_irq_oe_n_r <= `APM_RST_ONE;
      end else begin
        isa_oe_n_r <= 3'h7;
        isa_out_r <= 3'h0;
        pci_irq_oe_n_r <= ~(pci_irq_req_in & ~legacy_irq_mode_in);
      end
      // secondary pin: codec input or gpio
      if (secondary_codec_sel_in) begin
        sec_oe_n_r <= `APM_RST_ONE;
        gp1_rd_r <= `APM_RST_ZERO;
      end else begin
        sec_oe_n_r <= ~gp_io_one_oe_in;
        gp1_rd_r <= sec_s;
      end
      sec_out_r <= gp_io_one_out_in;
      // clock-run only pulls low when the pin reads high (clock stopping)
      clkrun_rd_r <= clkrun_n_s;
      clkrun_oe_n_r <= ~(clkrun_req_in & clkrun_n_s);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output wiring, straight from flip-flops except the constant-low drive levels
  assign cfg_mem_data_pin_out = 1'b0;
  assign cfg_mem_data_pin_oe_n_out = mem_data_oe_n_r;
  assign cfg_mem_clock_pin_out = mem_clk_r;
  assign cfg_mem_data_rd_out = mem_rd_r;
  assign legacy_dma_grant_n_out = grant_r;
  assign gp_io_two_rd_out = gp2_rd_r;
  assign gp_io_three_pin_out = gp3_out_r;
  assign gp_io_three_pin_oe_n_out = gp3_oe_n_r;
  assign gp_io_three_rd_out = gp3_rd_r;
  assign volume_up_button_rd_out = volume_up_button_rd_r;
  assign volume_down_button_rd_out = volume_down_button_rd_r;
  assign isa_irq_pin_out = isa_out_r;
  assign isa_irq_pin_oe_n_out = isa_oe_n_r;
  assign pci_irq_n_out = 1'b0;
  assign pci_irq_oe_n_out = pci_irq_oe_n_r;
  assign link_frame_sync_out = sync_r;
  assign link_serial_out = sdo_r;
  assign link_reset_n_out = link_rst_n_r;
  assign primary_data_out = prim_data_r;
  assign secondary_data_out = sec_data_r;
  assign link_bit_count_out = bit_cnt_r;
  assign secondary_pin_out = sec_out_r;
  assign secondary_pin_oe_n_out = sec_oe_n_r;
  assign gp_io_one_rd_out = gp1_rd_r;
  assign clkrun_pin_out = 1'b0;
  assign clkrun_pin_oe_n_out = clkrun_oe_n_r;
  assign clkrun_rd_out = clkrun_rd_r;
endmodule // apm_pin_mux

// ===== tb/apm_pin_mux_monitor.sv
// concurrent checks on the pin mux ports
`timescale 1ns/1ns
module apm_pin_mux_monitor (
  // watched ports, grouped by width to keep the list short
  input wire clk_sys_in, rst_n_in, pci_reset_n_in, sw_link_reset_bit_in,
  input wire gp_output_in, cfg_mem_clock_in, legacy_dma_request_n_in,
  input wire cfg_mem_clock_pin_out, cfg_mem_data_drive_low_in,
  input wire cfg_mem_data_pin_oe_n_out, gp_io_three_oe_in,
  input wire gp_io_three_pin_oe_n_out, legacy_irq_mode_in, isa_irq_enable_in,
  input wire link_reset_n_out, secondary_codec_sel_in, secondary_pin_oe_n_out,
  input wire clkrun_pin_n_in, clkrun_pin_oe_n_out, link_frame_sync_out,
  input wire link_power_down_in,
  input wire [1:0] mem_pin_mode_in,
  input wire [2:0] isa_irq_pin_oe_n_out,
  input wire [8:0] link_bit_count_out
);
  // single domain, so clock and reset are given once
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  //////////////////////////////////////////////////////////////////////////
  a_mem_clock_src: assert property (rst_n_in |=>
    cfg_mem_clock_pin_out ==
    ($past(mem_pin_mode_in) == 2'h1 ? $past(cfg_mem_clock_in) :
    $past(mem_pin_mode_in) == 2'h2 ? $past(legacy_dma_request_n_in) :
    $past(gp_output_in))) else $error("memory clock pin source wrong");
  a_mem_data_od: assert property (mem_pin_mode_in == 2'h1 |=>
    cfg_mem_data_pin_oe_n_out == !$past(cfg_mem_data_drive_low_in))
    else $error("memory data pin drive wrong");
  a_gp_three_float: assert property (!gp_io_three_oe_in |=>
    gp_io_three_pin_oe_n_out) else $error("third gpio driven unasked");
  a_isa_gate: assert property (!(legacy_irq_mode_in &&
    isa_irq_enable_in) |=> isa_irq_pin_oe_n_out == 3'h7)
    else $error("isa pins driven while not enabled");
  a_link_reset_or: assert property ((sw_link_reset_bit_in ||
    !pci_reset_n_in) [*3] |=> !link_reset_n_out)
    else $error("link reset not held low");
  a_sec_select: assert property (secondary_codec_sel_in |=>
    secondary_pin_oe_n_out) else $error("secondary pin driven as codec in");
  // a pin held low from outside for four cycles must not start the device driving it
  a_clkrun_quiet: assert property ((!clkrun_pin_n_in &&
    clkrun_pin_oe_n_out) [*4] |=> clkrun_pin_oe_n_out)
    else $error("clock-run driven while held low");
  a_slot_zero: assert property ($changed(link_bit_count_out) &&
    link_reset_n_out && !link_power_down_in |->
    link_frame_sync_out == (link_bit_count_out <= 9'h00F))
    else $error("frame sync not matching slot 0");
endmodule // apm_pin_mux_monitor

bind apm_pin_mux apm_pin_mux_monitor apm_pin_mux_monitor_i (.*);

// ===== tb/apm_codec_model.sv
// behavioural codec pair on the far side of the link
`timescale 1ns/1ns
module apm_codec_model (
  // link side
  input wire link_reset_n_in,
  input wire link_serial_in,
  input wire run_in,
  output reg bclk_out,
  output reg sdin_out,
  output reg sdin2_out
);
  // 80 ns bit clock, stands low in cold reset or sleep
  initial begin
    {bclk_out, sdin_out, sdin2_out} = 3'h0;
    forever begin
      #40;
      bclk_out = (run_in && link_reset_n_in) ? ~bclk_out : 1'b0;
    end
  end
  // echo what was sent; secondary inverted so the two are told apart
  always @(posedge bclk_out) begin
    sdin_out <= link_serial_in;
    sdin2_out <= ~link_serial_in;
  end
endmodule // apm_codec_model

// ===== tb/testbench.sv
// self-checking bench for the audio pin function mux
`timescale 1ns/1ns
module testbench;
  reg clk_sys_in, rst_n_in, pci_reset_n_in, gp_output_in, gp_io_two_out_in;
  reg gp_io_three_oe_in, gp_io_three_out_in, sw_link_reset_bit_in;
  reg secondary_codec_sel_in, gp_io_one_oe_in, gp_io_one_out_in;
  reg link_power_down_in, warm_reset_req_in, legacy_irq_mode_in;
  reg isa_irq_enable_in, pci_irq_req_in, clkrun_req_in, cfg_mem_clock_in;
  reg cfg_mem_data_drive_low_in, legacy_dma_request_n_in, link_serial_data_in;
  reg volume_up_button_n_in, volume_down_button_n_in, md_ext, ck_ext;
  reg [1:0] mem_pin_mode_in;
  reg [2:0] isa_irq_req_in;
  wire cfg_mem_data_rd_out, legacy_dma_grant_n_out, primary_data_out;
  wire secondary_data_out, gp_io_two_rd_out, gp_io_three_rd_out;
  wire gp_io_one_rd_out, volume_up_button_rd_out, volume_down_button_rd_out;
  wire clkrun_rd_out, cfg_mem_data_pin_out, cfg_mem_data_pin_oe_n_out;
  wire cfg_mem_clock_pin_out, gp_io_three_pin_out, gp_io_three_pin_oe_n_out;
  wire pci_irq_n_out, pci_irq_oe_n_out, link_frame_sync_out, link_serial_out;
  wire link_reset_n_out, secondary_pin_out, secondary_pin_oe_n_out, sd2;
  wire clkrun_pin_out, clkrun_pin_oe_n_out, link_bit_clock_in;
  wire primary_codec_serial_in, secondary_codec_serial_in;
  wire cfg_mem_data_pin_in, gp_io_three_pin_in, clkrun_pin_n_in;
  wire [2:0] isa_irq_pin_out, isa_irq_pin_oe_n_out;
  wire [8:0] link_bit_count_out;
  integer bad_count, samples_checked, cyc;
  //////////////////////////////////////////////////////////////////////////
  // pin levels: outside level on data, pull-up on gpio three, pull-down on pin one
  assign cfg_mem_data_pin_in = cfg_mem_data_pin_oe_n_out ? md_ext : 1'b0;
  assign gp_io_three_pin_in = gp_io_three_pin_oe_n_out ? 1'b1 :
    gp_io_three_pin_out;
  assign clkrun_pin_n_in = clkrun_pin_oe_n_out ? ck_ext : 1'b0;
  assign secondary_codec_serial_in = !secondary_pin_oe_n_out ?
    secondary_pin_out : secondary_codec_sel_in & sd2;
  apm_pin_mux apm_pin_mux_i (.*);
  apm_codec_model apm_codec_model_i (.link_reset_n_in(link_reset_n_out),
    .link_serial_in(link_serial_out), .run_in(!link_power_down_in),
    .bclk_out(link_bit_clock_in), .sdin_out(primary_codec_serial_in),
    .sdin2_out(sd2));
  //////////////////////////////////////////////////////////////////////////
  task w(input integer n); repeat (n) @(posedge clk_sys_in); endtask
  // sample 1 ns after the edge so its updates have landed
  task s(input integer n); begin w(n); #1; end endtask
  task chk(input [11:0] got, input [11:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  // wait for a sync level, bounded, returning cycles spent
  task ws(input v, output integer n);
    begin
      n = 0;
      while (link_frame_sync_out !== v && n < 4000) begin
        s(1);
        n = n + 1;
      end
    end
  endtask
  task give_verdict;
    begin
      if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // every mode against three one-hot source patterns
  task t_mem;
    integer m, j;
    reg [2:0] p;
    begin
      for (m = 0; m < 4; m = m + 1) for (j = 0; j < 3; j = j + 1) begin
        p = 3'h4 >> j;
        w(1);
        mem_pin_mode_in <= m[1:0];
        {gp_output_in, cfg_mem_clock_in, legacy_dma_request_n_in} <= p;
        {gp_io_two_out_in, cfg_mem_data_drive_low_in} <= {!p[0], p[0]};
        md_ext <= !p[0];
        s(5);
        chk(cfg_mem_clock_pin_out, m == 1 ? p[1] : m == 2 ? p[0] : p[2]);
        chk(cfg_mem_data_pin_oe_n_out, m == 2 || !p[0]);
        chk(m == 1 ? cfg_mem_data_rd_out : m == 2 ? legacy_dma_grant_n_out :
          gp_io_two_rd_out, !p[0]);
      end
    end
  endtask
  task t_gp;
    begin
      s(5);
      chk({gp_io_three_pin_oe_n_out, gp_io_three_rd_out}, 2'h3);
      w(1);
      gp_io_three_oe_in <= 1'b1;
      s(5);
      chk({gp_io_three_pin_oe_n_out, gp_io_three_rd_out}, 2'h0);
    end
  endtask
  task t_vol;
    integer k;
    reg [1:0] p;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        p = 2'h3 >> k;
        w(1);
        {volume_up_button_n_in, volume_down_button_n_in} <= p;
        s(5);
        chk({volume_up_button_rd_out, volume_down_button_rd_out}, p ^ 2'h3);
      end
    end
  endtask
  task t_isa;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        w(1);
        {legacy_irq_mode_in, isa_irq_enable_in} <= k[1:0];
        {isa_irq_req_in, pci_irq_req_in} <= 4'hB;
        s(3);
        chk(isa_irq_pin_oe_n_out == 3'h7, k != 3);
        chk(pci_irq_oe_n_out, k > 1);
        chk(isa_irq_pin_out, k == 3 ? 3'h5 : 3'h0);
      end
    end
  endtask
  task t_lrst;
    begin
      w(1);
      sw_link_reset_bit_in <= 1'b1;
      s(2);
      chk(link_reset_n_out, 1'b0);
      // pci reset asserts under the software bit so the synced path has
      // caught up before the software bit lets go
      w(1);
      pci_reset_n_in <= 1'b0;
      s(5);
      chk(link_reset_n_out, 1'b0);
      w(1);
      sw_link_reset_bit_in <= 1'b0;
      s(5);
      chk(link_reset_n_out, 1'b0);
      w(1);
      pci_reset_n_in <= 1'b1;
      s(6);
      chk(link_reset_n_out, 1'b1);
    end
  endtask
  // one frame at 8 system clocks per bit, then the data paths
  task t_link;
    integer n, hi, lo;
    begin
      w(1);
      {gp_io_one_oe_in, gp_io_one_out_in, link_serial_data_in} <= 3'h7;
      s(5);
      chk({secondary_pin_oe_n_out, gp_io_one_rd_out}, 2'h1);
      w(1);
      secondary_codec_sel_in <= 1'b1;
      ws(1'b0, n);
      ws(1'b1, n);
      ws(1'b0, hi);
      ws(1'b1, lo);
      chk(hi, 12'h080);
      chk(lo, 12'h780);
      chk(secondary_pin_oe_n_out, 1'b1);
      chk({link_serial_out, primary_data_out, secondary_data_out}, 3'h6);
      // flip the sent bit so both data inputs are seen to move
      w(1);
      link_serial_data_in <= 1'b0;
      s(40);
      chk({link_serial_out, primary_data_out, secondary_data_out}, 3'h1);
    end
  endtask
  task t_warm;
    integer n, hi;
    begin
      w(1);
      link_power_down_in <= 1'b1;
      ws(1'b0, n);
      w(1);
      warm_reset_req_in <= 1'b1;
      w(1);
      warm_reset_req_in <= 1'b0;
      ws(1'b1, n);
      ws(1'b0, hi);
      chk(hi, 12'h064);
      chk(link_bit_count_out, 12'h000);
      w(1);
      link_power_down_in <= 1'b0;
    end
  endtask
  task t_clkrun;
    begin
      // pin high with no request: released, and read back high
      w(1);
      ck_ext <= 1'b1;
      s(5);
      chk({clkrun_pin_oe_n_out, clkrun_rd_out}, 2'h3);
      // pin held low first, request only after it has settled
      w(1);
      ck_ext <= 1'b0;
      s(5);
      chk(clkrun_rd_out, 1'b0);
      w(1);
      clkrun_req_in <= 1'b1;
      s(12);
      chk(clkrun_pin_oe_n_out, 1'b1);
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // ceiling well above the roughly 4400 cycles the run needs
  always @(posedge clk_sys_in) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  end
  initial begin
    {bad_count, samples_checked, cyc} = 0;
    {rst_n_in, gp_output_in, gp_io_three_oe_in, gp_io_three_out_in} = 4'h0;
    {sw_link_reset_bit_in, secondary_codec_sel_in, gp_io_one_oe_in} = 3'h0;
    {gp_io_one_out_in, link_power_down_in, warm_reset_req_in} = 3'h0;
    {legacy_irq_mode_in, isa_irq_enable_in, pci_irq_req_in} = 3'h0;
    {clkrun_req_in, cfg_mem_clock_in, cfg_mem_data_drive_low_in} = 3'h0;
    {link_serial_data_in, mem_pin_mode_in, isa_irq_req_in, ck_ext} = 7'h00;
    {pci_reset_n_in, gp_io_two_out_in, legacy_dma_request_n_in} = 3'h7;
    {volume_up_button_n_in, volume_down_button_n_in, md_ext} = 3'h7;
    s(3);
    chk(isa_irq_pin_oe_n_out, 3'h7);
    chk(gp_io_three_pin_oe_n_out, 1'b1);
    chk(secondary_pin_oe_n_out, 1'b1);
    chk(link_reset_n_out, 1'b0);
    chk({cfg_mem_data_pin_out, clkrun_pin_out}, 2'h0);
    chk(pci_irq_n_out, 1'b0);
    w(1);
    rst_n_in <= 1'b1;
    t_mem;
    t_gp;
    t_vol;
    t_isa;
    t_lrst;
    t_link;
    t_warm;
    t_clkrun;
    give_verdict;
  end
endmodule // testbench
